// *** rtl/tcoc_pkg.sv ***
package tcoc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFS_CHAN_CTRL     = 4'h0;
  localparam logic [3:0] OFS_COMPARE_VALUE = 4'h1;
  localparam logic [3:0] OFS_STATUS        = 4'h2;

  // ****************************************
  // Field positions in channel control
  // ****************************************
  localparam int POS_MODE_SEL    = 0;
  localparam int POS_FAST_EN     = 2;
  localparam int POS_SHADOW_EN   = 3;
  localparam int POS_CMP_CTL     = 4;
  localparam int POS_CLEAR_EN    = 7;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0]  RST_CHAN_CTRL = 8'h00;
  localparam logic [1:0]  PROTECTION_LEVEL_LOCKED   = 2'h3;
  localparam logic [1:0]  MS_OUTPUT     = 2'h0;
  localparam logic [1:0]  MS_OWN        = 2'h1;
  localparam logic [1:0]  MS_NEIGHBOUR  = 2'h2;
  localparam logic [1:0]  MS_INTERNAL   = 2'h3;

  typedef enum logic [2:0] {
    CMP_TIMING     = 3'b000,
    CMP_SET        = 3'b001,
    CMP_CLEAR      = 3'b010,
    CMP_TOGGLE     = 3'b011,
    CMP_FORCE_LOW  = 3'b100,
    CMP_FORCE_HIGH = 3'b101,
    CMP_PWM0       = 3'b110,
    CMP_PWM1       = 3'b111
  } tcoc_cmp_mode_t;

endpackage

// *** rtl/tcoc_cfg_if.sv ***
`timescale 1ns/1ps
// Configuration and compare value from register file to engine
interface tcoc_cfg_if #(parameter int CW = 16);
  import tcoc_pkg::*;
  tcoc_cmp_mode_t cmp_mode;
  logic           clear_en;
  logic           fast_en;
  logic [CW-1:0]  active_cmp;
  logic           out_mode;
  modport regs (output cmp_mode, clear_en, fast_en, active_cmp, out_mode);
  modport eng  (input  cmp_mode, clear_en, fast_en, active_cmp, out_mode);
endinterface

// *** rtl/tcoc_sync2.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser, one per bit
module tcoc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  // ****************************************
  // Sync stages
  // ****************************************
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (srst) begin
        meta_ff[i] <= 1'b0;
        dout[i]    <= 1'b0;
      end else if (ce) begin
        meta_ff[i] <= din[i];
        dout[i]    <= meta_ff[i];
      end
    end
  end
endmodule

// *** rtl/tcoc_engine.sv ***
`timescale 1ns/1ps
// Output prepare generation from compare modes
module tcoc_engine #(
  parameter int CW = 16
) (
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire logic          ce,
  tcoc_cfg_if.eng            cfg,
  input  wire logic [CW-1:0] counter_value,
  input  wire logic          count_down,
  input  wire logic          ext_trig_sync,
  input  wire logic          trig_edge,
  output logic               prep_ff
);
  import tcoc_pkg::*;

  logic match;
  logic below;
  logic above;
  logic pwm_raw;
  logic pwm_lvl;
  logic is_pwm;
  logic nxt_prep;
  logic raw_prev_ff;
  logic timing_prev_ff;

  // ****************************************
  // Compare on kernel clock
  // ****************************************
  assign match  = (counter_value == cfg.active_cmp);
  assign below  = (counter_value <  cfg.active_cmp);
  assign above  = (counter_value >  cfg.active_cmp);
  assign is_pwm = (cfg.cmp_mode == CMP_PWM0) || (cfg.cmp_mode == CMP_PWM1);

  // Raw PWM level from the comparison in the current direction
  always_comb begin
    if (cfg.cmp_mode == CMP_PWM0) begin
      pwm_raw = count_down ? !above : below;
    end else begin
      pwm_raw = count_down ? above : !below;
    end
  end

  // Level moves on entry from timing, on a new result or on a fast edge
  always_comb begin
    pwm_lvl = prep_ff;
    if (timing_prev_ff || (pwm_raw != raw_prev_ff)) begin
      pwm_lvl = pwm_raw;
    end
    if (cfg.fast_en && is_pwm && trig_edge) begin
      pwm_lvl = (cfg.cmp_mode == CMP_PWM1);
    end
  end

  // Previous comparison result and previous mode, so a forced level sticks
  always_ff @(posedge mclk) begin
    if (srst) begin
      raw_prev_ff    <= 1'b0;
      timing_prev_ff <= 1'b1;
    end else if (ce) begin
      raw_prev_ff    <= pwm_raw;
      timing_prev_ff <= (cfg.cmp_mode == CMP_TIMING);
    end
  end

  // Next output prepare level
  always_comb begin
    nxt_prep = prep_ff;
    case (cfg.cmp_mode)
      CMP_TIMING:     nxt_prep = prep_ff;
      CMP_SET:        if (match) nxt_prep = 1'b1;
      CMP_CLEAR:      if (match) nxt_prep = 1'b0;
      CMP_TOGGLE:     if (match) nxt_prep = !prep_ff;
      CMP_FORCE_LOW:  nxt_prep = 1'b0;
      CMP_FORCE_HIGH: nxt_prep = 1'b1;
      CMP_PWM0,
      CMP_PWM1:       nxt_prep = pwm_lvl;
      default:        nxt_prep = prep_ff;
    endcase
    if (cfg.clear_en && ext_trig_sync) begin
      nxt_prep = 1'b0;
    end
    if (!cfg.out_mode) begin
      nxt_prep = prep_ff;
    end
  end

  // Output prepare register
  always_ff @(posedge mclk) begin
    if (srst) begin
      prep_ff <= 1'b0;
    end else if (ce) begin
      prep_ff <= nxt_prep;
    end
  end

endmodule

// *** rtl/tcoc_top.sv ***
`timescale 1ns/1ps
// Timer channel 0 output compare and mode selection
module tcoc_top #(
  parameter int CW = 16
) (
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  input  wire logic [CW-1:0] counter_value,
  input  wire logic          count_down,
  input  wire logic          update_event,
  input  wire logic          channel_enable_bit,
  input  wire logic [1:0]    protection_level,
  input  wire logic          main_output_polarity,
  input  wire logic          complementary_output_polarity,
  input  wire logic          filtered_external_trigger,
  input  wire logic          trigger_input,
  input  wire logic          own_filtered_input,
  input  wire logic          neighbour_filtered_input,
  input  wire logic          internal_trigger_signal,
  output logic               output_prepare_signal,
  output logic               channel_main_output,
  output logic               channel_complementary_output,
  output logic               channel_input_selected,
  output logic               channel_is_output
);
  import tcoc_pkg::*;

  tcoc_cfg_if #(.CW(CW)) cfg_bus ();

  logic [2:0]    cmp_ctl_ff;
  logic          shadow_en_ff;
  logic          fast_en_ff;
  logic          clear_en_ff;
  logic [1:0]    mode_sel_ff;
  logic [CW-1:0] cmp_wr_ff;
  logic [CW-1:0] cmp_act_ff;
  logic [CW-1:0] nxt_cmp_act;
  logic [31:0]   nxt_rdata;
  logic [31:0]   reg_rdata_ff;
  logic          locked;
  logic          wr_ctrl;
  logic          wr_cmp;
  logic          prep;
  logic          trig_prev_ff;
  logic          trig_edge;
  logic          sel_ff;
  logic          nxt_sel;
  logic [4:0]    sync_in;
  logic [4:0]    sync_out;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign sync_in = {filtered_external_trigger, trigger_input, own_filtered_input,
                    neighbour_filtered_input, internal_trigger_signal};

  tcoc_sync2 #(.W(5)) u_sync (
    .mclk (mclk),
    .srst (srst),
    .ce   (ce),
    .din  (sync_in),
    .dout (sync_out)
  );

  // Trigger rising edge after synchroniser
  always_ff @(posedge mclk) begin
    if (srst) begin
      trig_prev_ff <= 1'b0;
    end else if (ce) begin
      trig_prev_ff <= sync_out[3];
    end
  end
  assign trig_edge = sync_out[3] && !trig_prev_ff;

  // ****************************************
  // Register writes
  // ****************************************
  assign wr_ctrl = reg_wr && (reg_addr == OFS_CHAN_CTRL);
  assign wr_cmp  = reg_wr && (reg_addr == OFS_COMPARE_VALUE);
  assign locked  = (protection_level == PROTECTION_LEVEL_LOCKED) && (mode_sel_ff == MS_OUTPUT);

  // Compare control and shadow enable, frozen when locked
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_ctl_ff   <= RST_CHAN_CTRL[POS_CMP_CTL +: 3];
      shadow_en_ff <= RST_CHAN_CTRL[POS_SHADOW_EN];
    end else if (ce && wr_ctrl && !locked) begin
      cmp_ctl_ff   <= reg_wdata[POS_CMP_CTL +: 3];
      shadow_en_ff <= reg_wdata[POS_SHADOW_EN];
    end
  end

  // Fast and clear enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      fast_en_ff  <= RST_CHAN_CTRL[POS_FAST_EN];
      clear_en_ff <= RST_CHAN_CTRL[POS_CLEAR_EN];
    end else if (ce && wr_ctrl) begin
      fast_en_ff  <= reg_wdata[POS_FAST_EN];
      clear_en_ff <= reg_wdata[POS_CLEAR_EN];
    end
  end

  // Mode select, writable only with channel disabled
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_sel_ff <= RST_CHAN_CTRL[POS_MODE_SEL +: 2];
    end else if (ce && wr_ctrl && !channel_enable_bit) begin
      mode_sel_ff <= reg_wdata[POS_MODE_SEL +: 2];
    end
  end

  // ****************************************
  // Compare value and shadow
  // ****************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_wr_ff <= '0;
    end else if (ce && wr_cmp) begin
      cmp_wr_ff <= reg_wdata[CW-1:0];
    end
  end

  // Active compare: at update if shadowed, else at once
  always_comb begin
    nxt_cmp_act = cmp_act_ff;
    if (!shadow_en_ff && wr_cmp) begin
      nxt_cmp_act = reg_wdata[CW-1:0];
    end else if (!shadow_en_ff) begin
      nxt_cmp_act = cmp_wr_ff;
    end else if (update_event) begin
      nxt_cmp_act = cmp_wr_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_act_ff <= '0;
    end else if (ce) begin
      cmp_act_ff <= nxt_cmp_act;
    end
  end

  // ****************************************
  // Engine
  // ****************************************
  assign cfg_bus.cmp_mode   = tcoc_cmp_mode_t'(cmp_ctl_ff);
  assign cfg_bus.clear_en   = clear_en_ff;
  assign cfg_bus.fast_en    = fast_en_ff;
  assign cfg_bus.active_cmp = cmp_act_ff;
  assign cfg_bus.out_mode   = (mode_sel_ff == MS_OUTPUT);

  tcoc_engine #(.CW(CW)) u_eng (
    .mclk          (mclk),
    .srst          (srst),
    .ce            (ce),
    .cfg           (cfg_bus),
    .counter_value (counter_value),
    .count_down    (count_down),
    .ext_trig_sync (sync_out[4]),
    .trig_edge     (trig_edge),
    .prep_ff       (prep)
  );

  // ****************************************
  // Outputs and input selection
  // ****************************************
  assign output_prepare_signal        = prep;
  assign channel_main_output          = prep ^ main_output_polarity;
  assign channel_complementary_output = !prep ^ complementary_output_polarity;
  assign channel_is_output            = (mode_sel_ff == MS_OUTPUT);

  // Input source mux
  always_comb begin
    case (mode_sel_ff)
      MS_OWN:       nxt_sel = sync_out[2];
      MS_NEIGHBOUR: nxt_sel = sync_out[1];
      MS_INTERNAL:  nxt_sel = sync_out[0];
      default:      nxt_sel = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sel_ff <= 1'b0;
    end else if (ce) begin
      sel_ff <= nxt_sel;
    end
  end
  assign channel_input_selected = sel_ff;

  // ****************************************
  // Register read
  // ****************************************
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      OFS_CHAN_CTRL: begin
        nxt_rdata[POS_MODE_SEL +: 2] = mode_sel_ff;
        nxt_rdata[POS_FAST_EN]       = fast_en_ff;
        nxt_rdata[POS_SHADOW_EN]     = shadow_en_ff;
        nxt_rdata[POS_CMP_CTL +: 3]  = cmp_ctl_ff;
        nxt_rdata[POS_CLEAR_EN]      = clear_en_ff;
      end
      OFS_COMPARE_VALUE: nxt_rdata[CW-1:0] = cmp_wr_ff;
      OFS_STATUS: begin
        nxt_rdata[0] = prep;
        nxt_rdata[1] = sel_ff;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 32'h0000_0000;
    end
  end
  assign reg_rdata = reg_rdata_ff;
endmodule

// *** verification/tcoc_monitor.sv ***
`timescale 1ns/1ps
// ****************
// Compare checker
// ****************
module tcoc_monitor #(
  parameter int CW = 16
) (
  input wire logic          mclk,
  input wire logic          srst,
  input wire logic [3:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic [CW-1:0] counter_value,
  input wire logic          count_down,
  input wire logic          update_event,
  input wire logic          channel_enable_bit,
  input wire logic [1:0]    protection_level,
  input wire logic          main_output_polarity,
  input wire logic          complementary_output_polarity,
  input wire logic          filtered_external_trigger,
  input wire logic          output_prepare_signal,
  input wire logic          channel_main_output,
  input wire logic          channel_complementary_output
);
  import tcoc_pkg::*;
  logic [7:0]    cc_ff;
  logic [CW-1:0] cv_ff;
  logic [CW-1:0] av_ff;
  logic [2:0]    md;
  logic          ok;
  logic          hit;
  logic          r_w;
  logic          pw;

  // Accepted control writes, lock and enable gating
  always_ff @(posedge mclk) begin
    if (srst) begin
      cc_ff <= RST_CHAN_CTRL;
    end else if (reg_wr && reg_addr == OFS_CHAN_CTRL) begin
      cc_ff[7] <= reg_wdata[7];
      cc_ff[2] <= reg_wdata[2];
      if (protection_level != PROTECTION_LEVEL_LOCKED || cc_ff[1:0] != MS_OUTPUT) begin
        cc_ff[6:3] <= reg_wdata[6:3];
      end
      if (!channel_enable_bit) begin
        cc_ff[1:0] <= reg_wdata[1:0];
      end
    end
  end

  // Written compare value
  always_ff @(posedge mclk) begin
    if (srst) begin
      cv_ff <= '0;
    end else if (reg_wr && reg_addr == OFS_COMPARE_VALUE) begin
      cv_ff <= reg_wdata[CW-1:0];
    end
  end

  // Active compare value, direct or loaded at update
  always_ff @(posedge mclk) begin
    if (srst) begin
      av_ff <= '0;
    end else if (reg_wr && reg_addr == OFS_COMPARE_VALUE && !cc_ff[3]) begin
      av_ff <= reg_wdata[CW-1:0];
    end else if (update_event || !cc_ff[3]) begin
      av_ff <= cv_ff;
    end
  end

  // Decoded conditions
  assign md  = cc_ff[6:4];
  assign ok  = cc_ff[1:0] == MS_OUTPUT && !cc_ff[7];
  assign hit = counter_value == av_ff;
  assign r_w = count_down ? counter_value <= av_ff : counter_value < av_ff;
  assign pw  = r_w ^ md[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ****************
  // Properties
  // ****************
  sequence clr_held;
    (cc_ff[7] && cc_ff[1:0] == MS_OUTPUT && filtered_external_trigger) [*4];
  endsequence
  sequence held(logic [2:0] m);
    (ok && md == m) [*2];
  endsequence
  sequence pwm_turn;
    ok && !cc_ff[2] && md[2:1] == 2'b11 && $stable(md) && $changed(r_w);
  endsequence
  sequence pwm_keep;
    ok && !cc_ff[2] && md[2:1] == 2'b11 && $stable(md) && $stable(r_w);
  endsequence

  a_clear_low: assert property (clr_held |=> !output_prepare_signal)
    else $error("prepare not cleared");
  a_timing_hold: assert property (held(CMP_TIMING) |-> $stable(output_prepare_signal))
    else $error("prepare moved in timing mode");
  a_force_low: assert property (held(CMP_FORCE_LOW) |-> !output_prepare_signal)
    else $error("force low failed");
  a_force_high: assert property (held(CMP_FORCE_HIGH) |-> output_prepare_signal)
    else $error("force high failed");
  a_set_match: assert property (ok && md == CMP_SET && hit |=> output_prepare_signal)
    else $error("set on match failed");
  a_toggle_match: assert property (ok && md == CMP_TOGGLE && hit |=> $changed(output_prepare_signal))
    else $error("toggle on match failed");
  a_pwm_follow: assert property (pwm_turn |=> output_prepare_signal == $past(pw))
    else $error("pwm level wrong");
  a_pwm_hold: assert property (pwm_keep |=> $stable(output_prepare_signal))
    else $error("pwm level moved without cause");
  a_main_pol: assert property (channel_main_output == (output_prepare_signal ^ main_output_polarity))
    else $error("main polarity wrong");
  a_comp_pol: assert property (channel_complementary_output ==
    (!output_prepare_signal ^ complementary_output_polarity))
    else $error("complementary polarity wrong");
endmodule

bind tcoc_top tcoc_monitor #(.CW(CW)) u_mon (
  .mclk                          (mclk),
  .srst                          (srst),
  .reg_addr                      (reg_addr),
  .reg_wdata                     (reg_wdata),
  .reg_wr                        (reg_wr),
  .counter_value                 (counter_value),
  .count_down                    (count_down),
  .update_event                  (update_event),
  .channel_enable_bit            (channel_enable_bit),
  .protection_level              (protection_level),
  .main_output_polarity          (main_output_polarity),
  .complementary_output_polarity (complementary_output_polarity),
  .filtered_external_trigger     (filtered_external_trigger),
  .output_prepare_signal         (output_prepare_signal),
  .channel_main_output           (channel_main_output),
  .channel_complementary_output  (channel_complementary_output)
);

// *** verification/tcoc_top_bench.sv ***
`timescale 1ns/1ps
// ****************
// Compare bench
// ****************
module tcoc_top_bench;
  import tcoc_pkg::*;
  logic        mclk, srst, ce, reg_wr, reg_rd, count_down, update_event;
  logic        channel_enable_bit, main_output_polarity, complementary_output_polarity;
  logic        filtered_external_trigger, trigger_input, own_filtered_input;
  logic        neighbour_filtered_input, internal_trigger_signal, output_prepare_signal;
  logic        channel_main_output, channel_complementary_output;
  logic        channel_input_selected, channel_is_output, p;
  logic [1:0]  protection_level;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] counter_value, cv;
  logic [31:0] exq[$];
  logic        rd_ff = 1'b0;
  int          fail_count, num_checks, i, m;

  tcoc_top u_dut (
    .mclk                          (mclk),
    .srst                          (srst),
    .ce                            (ce),
    .reg_addr                      (reg_addr),
    .reg_wdata                     (reg_wdata),
    .reg_wr                        (reg_wr),
    .reg_rd                        (reg_rd),
    .reg_rdata                     (reg_rdata),
    .counter_value                 (counter_value),
    .count_down                    (count_down),
    .update_event                  (update_event),
    .channel_enable_bit            (channel_enable_bit),
    .protection_level              (protection_level),
    .main_output_polarity          (main_output_polarity),
    .complementary_output_polarity (complementary_output_polarity),
    .filtered_external_trigger     (filtered_external_trigger),
    .trigger_input                 (trigger_input),
    .own_filtered_input            (own_filtered_input),
    .neighbour_filtered_input      (neighbour_filtered_input),
    .internal_trigger_signal       (internal_trigger_signal),
    .output_prepare_signal         (output_prepare_signal),
    .channel_main_output           (channel_main_output),
    .channel_complementary_output  (channel_complementary_output),
    .channel_input_selected        (channel_input_selected),
    .channel_is_output             (channel_is_output)
  );

  // Clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [31:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exq.push_back(e);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic want(int md, logic lv);
    if (md == 0 || md == 7) return lv;
    if (md == 3 || md == 6) return !lv;
    return md[0];
  endfunction

  // Read data watcher
  always @(posedge mclk) begin
    rd_ff <= reg_rd;
    if (rd_ff) chk("rdata", exq.pop_front(), reg_rdata);
  end

  // Watchdog
  initial begin
    tick(5000);
    fail_count++;
    close_out();
  end

  // Main sequence
  initial begin
    void'($urandom(67944));
    {ce, srst, reg_wr, reg_rd, update_event, channel_enable_bit} = 6'h30;
    {filtered_external_trigger, trigger_input, own_filtered_input} = 3'h0;
    {neighbour_filtered_input, internal_trigger_signal, count_down} = 3'h0;
    {main_output_polarity, complementary_output_polarity} = 2'($urandom);
    protection_level = 2'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    counter_value = 16'h0000;
    tick(6);
    srst <= 1'b0;
    rd(OFS_CHAN_CTRL, 32'h0);
    rd(4'hF, 32'h0);
    // Every compare mode from both start levels and directions
    cv = 16'h0100 + 16'($urandom % 32'hFE00);
    wr(OFS_COMPARE_VALUE, {16'h0, cv});
    for (i = 0; i < 32; i++) begin
      m = i % 8;
      p = i[3];
      count_down <= i[4];
      counter_value <= p ? cv + 16'h1 : cv - 16'h1;
      wr(OFS_CHAN_CTRL, p ? 32'h50 : 32'h40);
      wr(OFS_CHAN_CTRL, 32'h00);
      wr(OFS_CHAN_CTRL, 32'(m) << 4);
      tick(2);
      counter_value <= cv;
      tick(1);
      counter_value <= p ? cv + 16'h1 : cv - 16'h1;
      tick(3);
      rd(OFS_STATUS, 32'(want(m, p)));
      chk("main", 32'(want(m, p) ^ main_output_polarity), 32'(channel_main_output));
      chk("comp", 32'(!want(m, p) ^ complementary_output_polarity),
          32'(channel_complementary_output));
    end
    // External clear, enabled then disabled
    wr(OFS_CHAN_CTRL, 32'hD0);
    filtered_external_trigger <= 1'b1;
    tick(5);
    rd(OFS_STATUS, 32'h0);
    filtered_external_trigger <= 1'b0;
    tick(5);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_CHAN_CTRL, 32'h50);
    filtered_external_trigger <= 1'b1;
    tick(5);
    rd(OFS_STATUS, 32'h1);
    filtered_external_trigger <= 1'b0;
    // Locked control fields
    wr(OFS_CHAN_CTRL, 32'h40);
    protection_level <= 2'h3;
    wr(OFS_CHAN_CTRL, 32'h5C);
    rd(OFS_CHAN_CTRL, 32'h44);
    rd(OFS_STATUS, 32'h0);
    protection_level <= 2'h0;
    // Mode select gating and sources
    channel_enable_bit <= 1'b1;
    wr(OFS_CHAN_CTRL, 32'h01);
    rd(OFS_CHAN_CTRL, 32'h00);
    chk("dir", 32'h1, 32'(channel_is_output));
    channel_enable_bit <= 1'b0;
    for (i = 2; i < 8; i++) begin
      m = i / 2;
      p = i[0];
      wr(OFS_CHAN_CTRL, 32'(m));
      own_filtered_input <= p ^ (m != 1);
      neighbour_filtered_input <= p ^ (m != 2);
      internal_trigger_signal <= p ^ (m != 3);
      tick(6);
      rd(OFS_STATUS, {30'h0, p, 1'b0});
      chk("sel", 32'(p), 32'(channel_input_selected));
      chk("dir", 32'h0, 32'(channel_is_output));
    end
    {own_filtered_input, neighbour_filtered_input, internal_trigger_signal} <= 3'h0;
    // Shadowed compare value
    counter_value <= 16'h0200;
    count_down <= 1'b0;
    wr(OFS_COMPARE_VALUE, 32'h100);
    wr(OFS_CHAN_CTRL, 32'h68);
    wr(OFS_COMPARE_VALUE, 32'h300);
    tick(3);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_COMPARE_VALUE, 32'h300);
    update_event <= 1'b1;
    tick(1);
    update_event <= 1'b0;
    tick(3);
    rd(OFS_STATUS, 32'h1);
    // Fast trigger path
    wr(OFS_CHAN_CTRL, 32'h0C);
    wr(OFS_CHAN_CTRL, 32'h7C);
    tick(3);
    rd(OFS_STATUS, 32'h0);
    trigger_input <= 1'b1;
    tick(8);
    rd(OFS_STATUS, 32'h1);
    tick(2);
    close_out();
  end
endmodule
